// file: rtl/video_capture_path.sv
// Notes on behaviour
// - scaler keeps programmed input and output sizes
// - every frame leaves at exact programmed output size
// - no parser requests while fabricating missing data
// - full 4k-byte buffer backs up into parser overflow
// - parser drops pixels and lines while overflowed
// - short input frame starts fabrication of missing data
// - fabrication runs every cycle the buffer has room, unpaced by video
// - single channel, scaler inline with parser only
// - overflow corrupts video but never locks path
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
module video_capture_path #(
    parameter int BUF_DEPTH = video_capture_pkg::BUF_DEPTH
) (
    input  wire logic                                clk_sys,
    input  wire logic                                nrst,
    input  wire logic [7:0]                          reg_addr,
    input  wire logic [31:0]                         reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [31:0]                         reg_rdata,
    input  wire logic                                vid_valid,
    input  wire video_capture_pkg::pix_t             vid_pix,
    output logic                                     mem_valid,
    output logic      [video_capture_pkg::PIX_W-1:0] mem_data,
    input  wire logic                                mem_ready,
    output logic                                     irq
);

    localparam int AW = $clog2(BUF_DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic                           port_en;
        logic                           port_rst;
        logic                           fifo_rst;
        logic [15:0]                    in_w;
        logic [15:0]                    in_h;
        logic [15:0]                    out_w;
        logic [15:0]                    out_h;
        logic [3:0]                     status;
        logic [3:0]                     mask;
        logic [31:0]                    rdata;
        logic                           abort_pend;
        logic                           ovf;
        video_capture_pkg::scl_state_t  st;
        logic                           fab_line;
        logic [16:0]                    acc_x;
        logic [16:0]                    acc_y;
        logic [15:0]                    out_x;
        logic [15:0]                    out_y;
    } path_state_t;

    path_state_t cur_ff;
    path_state_t nxt_cur;

    logic                                buf_in_valid;
    logic [video_capture_pkg::PIX_W-1:0] buf_in_data;
    logic                                buf_in_ready;
    logic [AW:0]                         buf_level;
    logic                                buf_flush;
    logic                                abort_wr;
    logic                                active;
    logic                                scl_req;
    logic                                take;
    logic                                drop;

    ////////////////////////////////////////////////////////////////////////////////
    // capture buffer toward memory
    // a flush empties it for an abort or a held port reset
    assign abort_wr  = reg_wr & (reg_addr == video_capture_pkg::OFS_ABORT)
                     & reg_wdata[video_capture_pkg::ABORT_GO];
    assign buf_flush = abort_wr | cur_ff.port_rst;

    capture_buffer #(
        .W     (video_capture_pkg::PIX_W),
        .DEPTH (BUF_DEPTH),
        .AW    (AW)
    ) u_capture_buffer (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .flush     (buf_flush),
        .in_valid  (buf_in_valid),
        .in_data   (buf_in_data),
        .in_ready  (buf_in_ready),
        .out_valid (mem_valid),
        .out_data  (mem_data),
        .out_ready (mem_ready),
        .level     (buf_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // parser handshake
    // the port runs only while enabled and out of both resets
    assign active  = cur_ff.port_en & ~cur_ff.port_rst & ~cur_ff.fifo_rst;
    // requests stop while fabricating or while the buffer is full
    assign scl_req = active & (cur_ff.st != video_capture_pkg::SCL_FAB) & buf_in_ready;
    assign take    = vid_valid & active & ~cur_ff.ovf & scl_req;
    // a pixel with no request behind it is lost
    assign drop    = vid_valid & active & (cur_ff.ovf | ~scl_req);
    assign irq     = |(cur_ff.status & cur_ff.mask);
    assign reg_rdata = cur_ff.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // next state: registers, parser, scaler
    always_comb begin
        logic [3:0]  ev;
        logic [3:0]  w1c;
        logic        frame_start;
        logic        row_keep;
        logic        col_keep;
        logic        eof_ev;
        logic        sof_ev;
        logic [31:0] rd_val;
        ev           = '0;
        w1c          = '0;
        frame_start  = 1'b0;
        row_keep     = 1'b0;
        col_keep     = 1'b0;
        eof_ev       = 1'b0;
        sof_ev       = 1'b0;
        rd_val       = '0;
        nxt_cur      = cur_ff;
        buf_in_valid = 1'b0;
        buf_in_data  = video_capture_pkg::FILL_PIXEL;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                video_capture_pkg::OFS_CTRL: begin
                    nxt_cur.port_en  = reg_wdata[video_capture_pkg::CTRL_PORT_EN];
                    nxt_cur.port_rst = reg_wdata[video_capture_pkg::CTRL_PORT_RST];
                    nxt_cur.fifo_rst = reg_wdata[video_capture_pkg::CTRL_FIFO_RST];
                end
                video_capture_pkg::OFS_IN_SIZE: begin
                    nxt_cur.in_w = reg_wdata[video_capture_pkg::SIZE_W_LSB +: 16];
                    nxt_cur.in_h = reg_wdata[video_capture_pkg::SIZE_H_LSB +: 16];
                end
                video_capture_pkg::OFS_OUT_SIZE: begin
                    nxt_cur.out_w = reg_wdata[video_capture_pkg::SIZE_W_LSB +: 16];
                    nxt_cur.out_h = reg_wdata[video_capture_pkg::SIZE_H_LSB +: 16];
                end
                video_capture_pkg::OFS_STATUS: begin
                    w1c = reg_wdata[video_capture_pkg::EV_BITS-1:0];
                end
                video_capture_pkg::OFS_MASK: begin
                    nxt_cur.mask = reg_wdata[video_capture_pkg::EV_BITS-1:0];
                end
                default: begin
                end
            endcase
        end

        // register reads, answered in the next cycle
        case (reg_addr)
            video_capture_pkg::OFS_CTRL: begin
                rd_val[video_capture_pkg::CTRL_PORT_EN]  = cur_ff.port_en;
                rd_val[video_capture_pkg::CTRL_PORT_RST] = cur_ff.port_rst;
                rd_val[video_capture_pkg::CTRL_FIFO_RST] = cur_ff.fifo_rst;
            end
            video_capture_pkg::OFS_IN_SIZE:  rd_val = {cur_ff.in_h, cur_ff.in_w};
            video_capture_pkg::OFS_OUT_SIZE: rd_val = {cur_ff.out_h, cur_ff.out_w};
            video_capture_pkg::OFS_STATUS:   rd_val[3:0] = cur_ff.status;
            video_capture_pkg::OFS_MASK:     rd_val[3:0] = cur_ff.mask;
            video_capture_pkg::OFS_STATE: begin
                rd_val[video_capture_pkg::STATE_OVF] = cur_ff.ovf;
                rd_val[video_capture_pkg::STATE_FAB] = (cur_ff.st == video_capture_pkg::SCL_FAB);
                rd_val[video_capture_pkg::STATE_LEVEL_LSB +: AW+1] = buf_level;
            end
            default: rd_val = '0;
        endcase
        nxt_cur.rdata = reg_rd ? rd_val : '0;

        // abort completes once the flush has been applied
        nxt_cur.abort_pend = abort_wr;
        ev[video_capture_pkg::EV_ABORT] = cur_ff.abort_pend;

        // parser: a drop opens overflow, the end of a line closes it
        if (drop) begin
            ev[video_capture_pkg::EV_OVERFLOW] = 1'b1;
            nxt_cur.ovf = ~(vid_pix.eol | vid_pix.eof);
        end
        if (!active) begin
            nxt_cur.ovf = 1'b0;
        end

        // start and end of frame pass even when the pixel itself is dropped, the end only outside fabrication
        sof_ev = vid_valid & active & vid_pix.sof;
        eof_ev = vid_valid & active & vid_pix.eof & ~(cur_ff.st == video_capture_pkg::SCL_FAB);

        // scaler
        case (cur_ff.st)
            video_capture_pkg::SCL_IDLE: begin
                if (sof_ev) begin
                    frame_start    = 1'b1;
                    nxt_cur.st     = video_capture_pkg::SCL_RUN;
                    nxt_cur.acc_x  = {1'b0, cur_ff.out_w};
                    nxt_cur.acc_y  = {1'b0, cur_ff.out_h};
                    nxt_cur.out_x  = '0;
                    nxt_cur.out_y  = '0;
                end
            end
            video_capture_pkg::SCL_RUN: begin
                if (sof_ev) begin
                    // new frame before the old one ended: fill the rest
                    ev[video_capture_pkg::EV_SHORT] = 1'b1;
                    nxt_cur.st       = video_capture_pkg::SCL_FAB;
                    nxt_cur.fab_line = 1'b0;
                end
            end
            video_capture_pkg::SCL_FAB: begin
                // fill one pixel every cycle the buffer takes it
                if (buf_in_ready && nxt_cur.out_y < cur_ff.out_h) begin
                    buf_in_valid = 1'b1;
                    if (cur_ff.out_x + 16'h0001 >= cur_ff.out_w) begin
                        nxt_cur.out_x = '0;
                        nxt_cur.out_y = cur_ff.out_y + 16'h0001;
                        if (cur_ff.fab_line) begin
                            nxt_cur.st = video_capture_pkg::SCL_RUN;
                        end
                    end else begin
                        nxt_cur.out_x = cur_ff.out_x + 16'h0001;
                    end
                end
                if (nxt_cur.out_y >= cur_ff.out_h) begin
                    ev[video_capture_pkg::EV_DONE] = 1'b1;
                    nxt_cur.st = video_capture_pkg::SCL_IDLE;
                end
            end
            default: nxt_cur.st = video_capture_pkg::SCL_IDLE;
        endcase

        // scaler: one input pixel sampled by running sums
        if (take && (frame_start || (cur_ff.st == video_capture_pkg::SCL_RUN && !sof_ev))) begin
            row_keep = nxt_cur.acc_y >= {1'b0, cur_ff.in_h};
            col_keep = nxt_cur.acc_x >= {1'b0, cur_ff.in_w};
            if (row_keep && col_keep && nxt_cur.out_x < cur_ff.out_w
                && nxt_cur.out_y < cur_ff.out_h) begin
                buf_in_valid  = 1'b1;
                buf_in_data   = vid_pix.data;
                nxt_cur.out_x = nxt_cur.out_x + 16'h0001;
            end
            nxt_cur.acc_x = (col_keep ? nxt_cur.acc_x - {1'b0, cur_ff.in_w} : nxt_cur.acc_x)
                          + {1'b0, cur_ff.out_w};
            if (vid_pix.eol) begin
                nxt_cur.acc_x = {1'b0, cur_ff.out_w};
                nxt_cur.acc_y = (row_keep ? nxt_cur.acc_y - {1'b0, cur_ff.in_h} : nxt_cur.acc_y)
                              + {1'b0, cur_ff.out_h};
                if (row_keep && nxt_cur.out_y < cur_ff.out_h) begin
                    if (nxt_cur.out_x < cur_ff.out_w) begin
                        // short line: pad it out before taking more
                        ev[video_capture_pkg::EV_SHORT] = 1'b1;
                        nxt_cur.st       = video_capture_pkg::SCL_FAB;
                        nxt_cur.fab_line = 1'b1;
                    end else begin
                        nxt_cur.out_x = '0;
                        nxt_cur.out_y = nxt_cur.out_y + 16'h0001;
                    end
                end
            end
        end

        // end of input frame: finish or fabricate what is missing
        if (eof_ev && (cur_ff.st == video_capture_pkg::SCL_RUN || frame_start)) begin
            if (nxt_cur.out_y >= cur_ff.out_h) begin
                ev[video_capture_pkg::EV_DONE] = 1'b1;
                nxt_cur.st = video_capture_pkg::SCL_IDLE;
            end else begin
                ev[video_capture_pkg::EV_SHORT] = 1'b1;
                nxt_cur.st       = video_capture_pkg::SCL_FAB;
                nxt_cur.fab_line = 1'b0;
            end
        end

        // port reset returns the scaler to idle; registers stay reachable
        if (cur_ff.port_rst || !cur_ff.port_en) begin
            nxt_cur.st       = video_capture_pkg::SCL_IDLE;
            nxt_cur.fab_line = 1'b0;
            nxt_cur.out_x    = '0;
            nxt_cur.out_y    = '0;
        end

        // sticky status: a set wins over a write-one clear
        nxt_cur.status = (cur_ff.status & ~w1c) | ev;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_ff            <= '0;
            cur_ff.port_en    <= video_capture_pkg::CTRL_RST[video_capture_pkg::CTRL_PORT_EN];
            cur_ff.port_rst   <= video_capture_pkg::CTRL_RST[video_capture_pkg::CTRL_PORT_RST];
            cur_ff.fifo_rst   <= video_capture_pkg::CTRL_RST[video_capture_pkg::CTRL_FIFO_RST];
            cur_ff.in_w       <= video_capture_pkg::SIZE_RST;
            cur_ff.in_h       <= video_capture_pkg::SIZE_RST;
            cur_ff.out_w      <= video_capture_pkg::SIZE_RST;
            cur_ff.out_h      <= video_capture_pkg::SIZE_RST;
            cur_ff.mask       <= video_capture_pkg::MASK_RST;
            cur_ff.st         <= video_capture_pkg::SCL_IDLE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

endmodule // video_capture_path

// file: include/video_capture_pkg.sv
package video_capture_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_IN_SIZE  = 8'h04;
    localparam logic [7:0] OFS_OUT_SIZE = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_MASK     = 8'h10;
    localparam logic [7:0] OFS_STATE    = 8'h14;
    localparam logic [7:0] OFS_ABORT    = 8'h18;

    // control field positions
    localparam int CTRL_PORT_EN  = 0;
    localparam int CTRL_PORT_RST = 1;
    localparam int CTRL_FIFO_RST = 2;
    localparam int ABORT_GO      = 0;

    // size fields: width low half, height high half
    localparam int SIZE_W_LSB = 0;
    localparam int SIZE_H_LSB = 16;
    localparam int SIZE_BITS  = 16;

    // status, mask and event bit positions
    localparam int EV_OVERFLOW = 0;
    localparam int EV_SHORT    = 1;
    localparam int EV_DONE     = 2;
    localparam int EV_ABORT    = 3;
    localparam int EV_BITS     = 4;

    // state register field positions
    localparam int STATE_OVF       = 0;
    localparam int STATE_FAB       = 1;
    localparam int STATE_LEVEL_LSB = 16;

    // reset values
    localparam logic [2:0]  CTRL_RST     = 3'h0;
    localparam logic [15:0] SIZE_RST     = 16'h0010;
    localparam logic [3:0]  MASK_RST     = 4'h0;

    // capture buffer size and pixel word
    localparam int          BUF_BYTES    = 4096;
    localparam int          PIX_W        = 32;
    localparam int          BUF_DEPTH    = BUF_BYTES / (PIX_W / 8);
    localparam logic [31:0] FILL_PIXEL   = 32'h0000_0000;

    // one pixel of the incoming video with its framing marks
    typedef struct packed {
        logic             sof;
        logic             eol;
        logic             eof;
        logic [PIX_W-1:0] data;
    } pix_t;

    typedef enum logic [1:0] {
        SCL_IDLE,
        SCL_RUN,
        SCL_FAB
    } scl_state_t;

endpackage

// file: rtl/capture_buffer.sv
`timescale 1ns/1ns
module capture_buffer #(
    parameter int W     = 32,
    parameter int DEPTH = 1024,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic          flush,
    input  wire logic          in_valid,
    input  wire logic [W-1:0]  in_data,
    output logic               in_ready,
    output logic               out_valid,
    output logic [W-1:0]       out_data,
    input  wire logic          out_ready,
    output logic [AW:0]        level
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             count;
    } buf_state_t;

    buf_state_t cur_ff;
    buf_state_t nxt_cur;
    logic       push;
    logic       pop;

    // full and empty come straight from the occupancy count
    assign in_ready  = (cur_ff.count != (AW+1)'(DEPTH));
    assign out_valid = (cur_ff.count != '0);
    assign out_data  = cur_ff.mem[cur_ff.rptr];
    assign level     = cur_ff.count;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer wrap at depth, flush empties without touching storage
    always_comb begin
        nxt_cur = cur_ff;
        if (push) begin
            nxt_cur.mem[cur_ff.wptr] = in_data;
            nxt_cur.wptr = (cur_ff.wptr == AW'(DEPTH - 1)) ? '0 : cur_ff.wptr + 1'b1;
        end
        if (pop) begin
            nxt_cur.rptr = (cur_ff.rptr == AW'(DEPTH - 1)) ? '0 : cur_ff.rptr + 1'b1;
        end
        nxt_cur.count = cur_ff.count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            nxt_cur.wptr  = '0;
            nxt_cur.rptr  = '0;
            nxt_cur.count = '0;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

endmodule // capture_buffer

// file: bench/video_capture_path_assertions.sv
`timescale 1ns/1ns
module video_capture_path_assertions #(
    parameter int BUF_DEPTH = video_capture_pkg::BUF_DEPTH
) (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        mem_valid,
    input wire logic [31:0] mem_data,
    input wire logic        mem_ready,
    input wire logic        irq
);
    localparam int AW = $clog2(BUF_DEPTH);
    logic [2:0]  ctrl_ff;
    logic [3:0]  mask_ff;
    logic [31:0] in_ff;
    logic        active;
    ////////////////////////////////////////////////////////////
    // shadow the control, mask and input size registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= video_capture_pkg::CTRL_RST;
            mask_ff <= video_capture_pkg::MASK_RST;
            in_ff   <= {2{video_capture_pkg::SIZE_RST}};
        end else if (reg_wr) begin
            if (reg_addr == video_capture_pkg::OFS_CTRL) ctrl_ff <= reg_wdata[2:0];
            if (reg_addr == video_capture_pkg::OFS_MASK) mask_ff <= reg_wdata[3:0];
            if (reg_addr == video_capture_pkg::OFS_IN_SIZE) in_ff <= reg_wdata;
        end
    end
    assign active = (ctrl_ff == 3'h1);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////
    chk_in_size_rd: assert property (
        reg_rd && reg_addr == video_capture_pkg::OFS_IN_SIZE |=> reg_rdata == in_ff)
        else $error("input size readback wrong");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside answer");
    chk_irq_masked: assert property (
        mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !irq) else $error("irq while masked");
    chk_port_rst_flush: assert property (
        ctrl_ff[1] [*2] |=> !mem_valid) else $error("buffer kept in port reset");
    chk_abort_flush: assert property (
        reg_wr && !active && reg_addr == video_capture_pkg::OFS_ABORT && reg_wdata[0]
        |=> !mem_valid) else $error("abort left data");
    chk_mem_hold: assert property (
        mem_valid && !mem_ready && ctrl_ff[2:1] == 2'h0 && !reg_wr
        |=> mem_valid && $stable(mem_data)) else $error("stalled word not held");
    chk_idle_quiet: assert property (
        (!active) [*2] ##0 !mem_valid |=> !mem_valid) else $error("data while port idle");
    chk_level_rd: assert property (
        reg_rd && reg_addr == video_capture_pkg::OFS_STATE
        |=> (reg_rdata[16+AW:16] != '0) == $past(mem_valid)) else $error("level disagrees");
    cover property (irq);
    cover property ((mem_valid && !mem_ready) [*4]);
    cover property (reg_wr && reg_addr == video_capture_pkg::OFS_ABORT);
endmodule // video_capture_path_assertions

// file: bench/video_source_model.sv
`timescale 1ns/1ns
module video_source_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        go,
    input  wire logic [15:0] cols,
    input  wire logic [15:0] cut_rows,
    input  wire logic [31:0] base,
    input  wire logic        stall,
    output logic             busy = 1'b0,
    output logic             vid_valid = 1'b0,
    output video_capture_pkg::pix_t vid_pix = '0,
    output logic             mem_ready
);
    int k = 0;
    // memory side stalls on request
    assign mem_ready = !stall;
    // one pixel a cycle; the source never waits
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy      <= 1'b0;
            vid_valid <= 1'b0;
            k         <= 0;
        end else if (busy) begin
            vid_valid    <= 1'b1;
            vid_pix.sof  <= (k == 0);
            vid_pix.eol  <= (k % int'(cols) == int'(cols) - 1);
            vid_pix.eof  <= (k == int'(cut_rows) * int'(cols) - 1);
            vid_pix.data <= base + 32'(k);
            k            <= k + 1;
            busy         <= (k != int'(cut_rows) * int'(cols) - 1);
        end else begin
            vid_valid <= 1'b0;
            vid_pix   <= {3'h0, ~vid_pix.data}; // idle data lines toggle, framing marks held low
            k         <= 0;
            busy      <= go;
        end
    end
endmodule // video_source_model

// file: bench/video_capture_scaler_overflow_test.sv
`timescale 1ns/1ns
module video_capture_scaler_overflow_test;
    localparam int DEPTH = 16;
    logic        clk_sys   = 1'b0;
    logic        nrst      = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        vid_valid;
    logic        mem_valid;
    logic [31:0] mem_data;
    logic        mem_ready;
    logic        irq;
    logic        go        = 1'b0;
    logic        stall     = 1'b1;
    logic        busy;
    logic [15:0] f_cols    = 16'h0001;
    logic [15:0] f_cut     = 16'h0001;
    logic [31:0] base      = 32'h0;
    logic [31:0] d;
    logic [31:0] got_q[$];
    int          seed      = 48644;
    int          n_errors  = 0;
    int          n_tests   = 0;
    video_capture_pkg::pix_t vid_pix;
    ////////////////////////////////////////////////////////////
    always #25 clk_sys = ~clk_sys;
    video_capture_path #(.BUF_DEPTH(DEPTH)) i_dut (.clk_sys, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .vid_valid, .vid_pix, .mem_valid, .mem_data,
        .mem_ready, .irq);
    video_source_model i_src (.clk_sys, .nrst, .go, .cols(f_cols), .cut_rows(f_cut), .base,
        .stall, .busy, .vid_valid, .vid_pix, .mem_ready);
    // words the memory side took
    always @(posedge clk_sys) if (nrst && mem_valid && mem_ready) got_q.push_back(mem_data);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    function automatic logic [31:0] exp_word(input int i, input int sent);
        return (i < sent) ? base + 32'(i) : video_capture_pkg::FILL_PIXEL;
    endfunction
    task automatic start(input int c, input int r, input int cut, input int oc, input int orow);
        wr(video_capture_pkg::OFS_IN_SIZE, {16'(r), 16'(c)});
        wr(video_capture_pkg::OFS_OUT_SIZE, {16'(orow), 16'(oc)});
        wr(video_capture_pkg::OFS_CTRL, 32'h1);
        f_cols <= 16'(c);
        f_cut  <= 16'(cut);
        go     <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    // one frame: c x cut sent into c x r input, oc x orow output
    task automatic frame(input int c, input int r, input int cut, input int oc, input int orow);
        int n;
        n = oc * orow;
        base = $random(seed);
        got_q.delete();
        start(c, r, cut, oc, orow);
        @(posedge clk_sys);
        while (busy) @(posedge clk_sys);
        for (int i = 0; i < n + 8 && got_q.size() < n; i++) @(posedge clk_sys);
        chk(32'(got_q.size()), 32'(n));
        if (oc == c && orow == r) for (int i = 0; i < n; i++) chk(got_q[i], exp_word(i, c * cut));
        rd(video_capture_pkg::OFS_STATUS);
        chk_bit(d[1], cut < r);
        chk_bit(d[2], 1'b1);
        wr(video_capture_pkg::OFS_STATUS, 32'hF);
    endtask
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]  ofs [6];
        logic [31:0] rv  [6];
        int          c;
        int          r;
        ofs = '{video_capture_pkg::OFS_CTRL, video_capture_pkg::OFS_IN_SIZE,
                video_capture_pkg::OFS_OUT_SIZE, video_capture_pkg::OFS_STATUS,
                video_capture_pkg::OFS_MASK, 8'h1C};
        rv  = '{32'h0, {2{video_capture_pkg::SIZE_RST}}, {2{video_capture_pkg::SIZE_RST}},
                32'h0, 32'h0, 32'h0};
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        wr(8'h1C, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i]);
            chk(d, rv[i]);
        end
        stall <= 1'b0;
        frame(4, 4, 4, 2, 2);
        frame(3, 2, 1, 3, 2);
        for (int i = 0; i < 6; i++) begin
            c = 2 + ($random(seed) & 3);
            r = 2 + ($random(seed) & 3);
            frame(c, r, (i % 2) ? r : 1 + (($random(seed) & 7) % (r - 1)), c, r);
        end
        // memory stalls: buffer fills and the parser overflows
        stall <= 1'b1;
        wr(video_capture_pkg::OFS_MASK, 32'h1);
        start(8, 4, 4, 8, 4);
        repeat (40) @(posedge clk_sys);
        rd(video_capture_pkg::OFS_STATUS);
        chk_bit(d[0], 1'b1);
        rd(video_capture_pkg::OFS_STATE);
        chk({27'h0, d[20:16]}, 32'(DEPTH));
        chk_bit(irq, 1'b1);
        wr(video_capture_pkg::OFS_MASK, 32'h0);
        chk_bit(irq, 1'b0);
        wr(video_capture_pkg::OFS_MASK, 32'h1);
        wr(video_capture_pkg::OFS_CTRL, 32'h0);
        wr(video_capture_pkg::OFS_CTRL, 32'h2);
        wr(video_capture_pkg::OFS_CTRL, 32'h6);
        wr(video_capture_pkg::OFS_ABORT, 32'h1);
        d = 32'h0;
        for (int i = 0; i < 20 && d[3] !== 1'b1; i++) rd(video_capture_pkg::OFS_STATUS);
        chk_bit(d[3], 1'b1);
        wr(video_capture_pkg::OFS_CTRL, 32'h4);
        wr(video_capture_pkg::OFS_CTRL, 32'h0);
        wr(video_capture_pkg::OFS_STATUS, 32'hF);
        chk_bit(irq, 1'b0);
        chk_bit(mem_valid, 1'b0);
        stall <= 1'b0;
        frame(4, 3, 3, 4, 3);
        end_sim();
    end
    // cut a hang short
    initial begin
        #(50 * 40000);
        n_errors++;
        end_sim();
    end
endmodule // video_capture_scaler_overflow_test
bind video_capture_path video_capture_path_assertions #(.BUF_DEPTH(BUF_DEPTH)) i_chk (
    .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_valid,
    .mem_data, .mem_ready, .irq);
